// ===== rtl/rce_async_reg.sv
`timescale 1ns/1ps
// register behind the asynchronous write path: a write lands in a staging
// copy and takes effect after RCE_SYNC_CYC cycles; busy shows the wait
module rce_async_reg
	import rce_pkg::*;
#(
	parameter int unsigned W = 24,
	parameter logic [W-1:0] RST = '0
)(
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rstn,
	// write side
	input  wire logic         wr_en,
	input  wire logic [W-1:0] wr_data,
	// live value and busy flag
	output logic      [W-1:0] value_q,
	output logic              busy_q
);
	logic [W-1:0] stage_q;
	logic [1:0]   wait_q;

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			stage_q <= RST;
			wait_q  <= 2'h0;
			busy_q  <= 1'b0;
			value_q <= RST;
		end
		else if (wr_en)
		begin
			stage_q <= wr_data;
			wait_q  <= 2'(RCE_SYNC_CYC - 1);
			busy_q  <= 1'b1;
		end
		else if (busy_q)
		begin
			if (wait_q == 2'h0)
			begin
				value_q <= stage_q;
				busy_q  <= 1'b0;
			end
			else
				wait_q <= wait_q - 2'h1;
		end
	end
endmodule // rce_async_reg

// ===== rtl/rce_pkg.sv
package rce_pkg;
	localparam int unsigned RCE_CNT_W     = 24;
	localparam int unsigned RCE_ADDR_W    = 8;
	localparam int unsigned RCE_DATA_W    = 32;
	localparam int unsigned RCE_FLAG_W    = 3;
	// register offsets (byte addresses)
	localparam logic [7:0] RCE_OFS_CTRL   = 8'h00;
	localparam logic [7:0] RCE_OFS_CNT    = 8'h04;
	localparam logic [7:0] RCE_OFS_CMPA   = 8'h08;
	localparam logic [7:0] RCE_OFS_CMPB   = 8'h0C;
	localparam logic [7:0] RCE_OFS_FLAGS  = 8'h10;
	localparam logic [7:0] RCE_OFS_FSET   = 8'h14;
	localparam logic [7:0] RCE_OFS_FCLR   = 8'h18;
	localparam logic [7:0] RCE_OFS_IEN    = 8'h1C;
	localparam logic [7:0] RCE_OFS_BUSY   = 8'h24;
	// flag bit positions
	localparam int unsigned RCE_BIT_OVF   = 0;
	localparam int unsigned RCE_BIT_CMPA  = 1;
	localparam int unsigned RCE_BIT_CMPB  = 2;
	// control bit positions
	localparam int unsigned RCE_CTRL_EN   = 0;
	localparam int unsigned RCE_CTRL_TOPA = 2;
	localparam int unsigned RCE_CTRL_W    = 3;
	// reset values and the counter maximum
	localparam logic [23:0] RCE_CMP_RST   = 24'h000000;
	localparam logic [23:0] RCE_CNT_MAX   = 24'hFFFFFF;
	localparam logic [2:0]  RCE_FLAG_RST  = 3'h0;
	localparam logic [2:0]  RCE_CTRL_RST  = 3'h0;
	// asynchronous write path: cycles from write to value taking effect
	localparam int unsigned RCE_SYNC_CYC  = 2;
endpackage

// ===== rtl/rce_top.sv
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module rce_top
	import rce_pkg::*;
(
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rstn,
	// register port
	input  wire logic [RCE_ADDR_W-1:0] reg_addr,
	input  wire logic [RCE_DATA_W-1:0] reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [RCE_DATA_W-1:0] reg_rdata_q,
	// events
	output logic                       irq_q,
	output logic                       timer_start_q
);
	import rce_pkg::*;

	logic [RCE_CTRL_W-1:0] ctrl_q;
	logic [RCE_CNT_W-1:0]  counter_value_q;
	logic [RCE_CNT_W-1:0]  compare_value_a;
	logic [RCE_CNT_W-1:0]  compare_value_b;
	logic                  busy_a;
	logic                  busy_b;
	logic [RCE_FLAG_W-1:0] flags_q;
	logic [RCE_FLAG_W-1:0] flags_d;
	logic [RCE_FLAG_W-1:0] enable_q;
	logic [RCE_FLAG_W-1:0] enable_d;
	logic [RCE_FLAG_W-1:0] hw_set;
	logic [RCE_FLAG_W-1:0] sw_set;
	logic [RCE_FLAG_W-1:0] sw_clr;
	logic                  match_a;
	logic                  match_b;
	logic                  wrap_top;
	logic                  wr_cnt;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	// upper write-data bits are simply dropped; software keeps them zero
	assign wr_cnt = reg_wr && hit(reg_addr, RCE_OFS_CNT);

	always_ff @(posedge mclk)
	begin
		if (!rstn)
			ctrl_q <= RCE_CTRL_RST;
		else if (reg_wr && hit(reg_addr, RCE_OFS_CTRL))
			ctrl_q <= reg_wdata[RCE_CTRL_W-1:0];
	end

	rce_async_reg #(
		.W   (RCE_CNT_W),
		.RST (RCE_CMP_RST)
	) u_cmp_a (
		.mclk    (mclk),
		.rstn    (rstn),
		.wr_en   (reg_wr && hit(reg_addr, RCE_OFS_CMPA)),
		.wr_data (reg_wdata[RCE_CNT_W-1:0]),
		.value_q (compare_value_a),
		.busy_q  (busy_a)
	);

	rce_async_reg #(
		.W   (RCE_CNT_W),
		.RST (RCE_CMP_RST)
	) u_cmp_b (
		.mclk    (mclk),
		.rstn    (rstn),
		.wr_en   (reg_wr && hit(reg_addr, RCE_OFS_CMPB)),
		.wr_data (reg_wdata[RCE_CNT_W-1:0]),
		.value_q (compare_value_b),
		.busy_q  (busy_b)
	);

	assign match_a = ctrl_q[RCE_CTRL_EN] && (counter_value_q == compare_value_a);
	assign match_b = ctrl_q[RCE_CTRL_EN] && (counter_value_q == compare_value_b);

	// top is compare a when selected, else the full 24-bit range
	assign wrap_top = ctrl_q[RCE_CTRL_TOPA] ? match_a
		: (counter_value_q == RCE_CNT_MAX);

	// counter clears in the cycle after reaching top; disabled counter holds zero
	always_ff @(posedge mclk)
	begin
		if (!rstn)
			counter_value_q <= RCE_CMP_RST;
		else if (!ctrl_q[RCE_CTRL_EN])
			counter_value_q <= RCE_CMP_RST;
		else if (wr_cnt)
			counter_value_q <= reg_wdata[RCE_CNT_W-1:0];
		else if (wrap_top)
			counter_value_q <= RCE_CMP_RST;
		else
			counter_value_q <= counter_value_q + 24'h000001;
	end

	always_comb
	begin
		hw_set = 3'h0;
		hw_set[RCE_BIT_OVF]  = ctrl_q[RCE_CTRL_EN] && !wr_cnt
			&& (counter_value_q == RCE_CNT_MAX);
		hw_set[RCE_BIT_CMPA] = match_a;
		hw_set[RCE_BIT_CMPB] = match_b;
	end

	// only ones act; zeros leave flags alone
	assign sw_set = (reg_wr && hit(reg_addr, RCE_OFS_FSET))
		? reg_wdata[RCE_FLAG_W-1:0] : 3'h0;
	assign sw_clr = (reg_wr && hit(reg_addr, RCE_OFS_FCLR))
		? reg_wdata[RCE_FLAG_W-1:0] : 3'h0;

	// set wins over a clear in the same cycle so no event is lost
	assign flags_d = (flags_q & ~sw_clr) | hw_set | sw_set;

	assign enable_d = (reg_wr && hit(reg_addr, RCE_OFS_IEN))
		? reg_wdata[RCE_FLAG_W-1:0] : enable_q;

	always_ff @(posedge mclk)
	begin
		if (!rstn)
			flags_q <= RCE_FLAG_RST;
		else
			flags_q <= flags_d;
	end

	always_ff @(posedge mclk)
	begin
		if (!rstn)
			enable_q <= RCE_FLAG_RST;
		else
			enable_q <= enable_d;
	end

	// irq is built from next-state values so it moves in the same cycle as the
	// flags and enables; the timer start pulse still trails its match by one cycle
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			irq_q         <= 1'b0;
			timer_start_q <= 1'b0;
		end
		else
		begin
			irq_q         <= |(flags_d & enable_d);
			timer_start_q <= match_b;
		end
	end

	// read data stands in the cycle after the read strobe only
	always_ff @(posedge mclk)
	begin
		if (!rstn)
			reg_rdata_q <= 32'h00000000;
		else if (reg_rd)
		begin
			case (reg_addr)
				RCE_OFS_CTRL:  reg_rdata_q <= {29'h0, ctrl_q};
				RCE_OFS_CNT:   reg_rdata_q <= {8'h00, counter_value_q};
				RCE_OFS_CMPA:  reg_rdata_q <= {8'h00, compare_value_a};
				RCE_OFS_CMPB:  reg_rdata_q <= {8'h00, compare_value_b};
				RCE_OFS_FLAGS: reg_rdata_q <= {29'h0, flags_q};
				RCE_OFS_IEN:   reg_rdata_q <= {29'h0, enable_q};
				RCE_OFS_BUSY:  reg_rdata_q <= {29'h0, busy_b, busy_a, 1'b0};
				default:       reg_rdata_q <= 32'h00000000;
			endcase
		end
		else
			reg_rdata_q <= 32'h00000000;
	end
endmodule // rce_top

// ===== tb/rce_chk_assertions.sv
`timescale 1ns/1ps
module rce_chk
	import rce_pkg::*;
(
	// clock and reset
	input wire logic        mclk,
	input wire logic        rstn,
	// register port
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata_q,
	// events
	input wire logic        irq_q,
	input wire logic        timer_start_q
);
	wire logic rdf = reg_rd && reg_addr == RCE_OFS_FLAGS;
	wire logic wset = reg_wr && reg_addr == RCE_OFS_FSET;
	wire logic wien = reg_wr && reg_addr == RCE_OFS_IEN;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// the idle cycle between set and read keeps a clear from landing in between
	property p_set_o;
		wset && reg_wdata[0] ##1 !reg_wr ##1 rdf |=> reg_rdata_q[0];
	endproperty
	a_set_o: assert property (p_set_o) else $error("overflow flag not set");
	property p_set_a;
		wset && reg_wdata[1] ##1 !reg_wr ##1 rdf |=> reg_rdata_q[1];
	endproperty
	a_set_a: assert property (p_set_a) else $error("compare a flag not set");
	property p_set_b;
		wset && reg_wdata[2] ##1 !reg_wr ##1 rdf |=> reg_rdata_q[2];
	endproperty
	a_set_b: assert property (p_set_b) else $error("compare b flag not set");
	property p_wo_zero;
		reg_rd && (reg_addr == RCE_OFS_FSET || reg_addr == RCE_OFS_FCLR) |=> reg_rdata_q == 32'h0;
	endproperty
	a_wo_zero: assert property (p_wo_zero) else $error("set or clear reads nonzero");
	property p_flag_rsv;
		rdf |=> reg_rdata_q[31:3] == 29'h0;
	endproperty
	a_flag_rsv: assert property (p_flag_rsv) else $error("flag reserved bits set");
	property p_cmpb_rsv;
		reg_rd && reg_addr == RCE_OFS_CMPB |=> reg_rdata_q[31:24] == 8'h0;
	endproperty
	a_cmpb_rsv: assert property (p_cmpb_rsv) else $error("compare reserved bits set");
	property p_irq_on;
		wien && reg_wdata[2:0] == 3'h7 ##1 !reg_wr ##1 wset && reg_wdata[2:0] != 3'h0
			|=> irq_q;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("irq missing");
	property p_irq_off;
		wien && reg_wdata[2:0] == 3'h0 |=> !irq_q;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq while masked");
endmodule // rce_chk

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
	import rce_pkg::*;
	logic        mclk, rstn, reg_wr, reg_rd, irq_q, timer_start_q;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata_q;
	int          n_fail, checked, pulses;
	rce_top dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .irq_q(irq_q),
		.timer_start_q(timer_start_q));
	initial
	begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) if (timer_start_q) pulses++;
	task chk(string nm, logic [31:0] got, logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wr(logic [7:0] a, logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask
	task rd(logic [7:0] a, logic [31:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk("rdata", reg_rdata_q, exp);
		@(posedge mclk);
	endtask
	task give_verdict;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task run(logic [2:0] ctl, logic [31:0] cnt, logic [31:0] fl, int np);
		wr(RCE_OFS_CTRL, {29'h0, ctl});
		wr(RCE_OFS_CNT, cnt);
		repeat (20) @(posedge mclk);
		wr(RCE_OFS_CTRL, 32'h0);
		rd(RCE_OFS_FLAGS, fl);
		chk("pulses", 32'(pulses), 32'(np));
	endtask
	initial
	begin
		{rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		rd(RCE_OFS_CMPB, 32'h0);
		rd(RCE_OFS_FLAGS, 32'h0);
		chk("irq", {31'h0, irq_q}, 32'h0);
		wr(RCE_OFS_CMPB, 32'h00A5A5A5);
		rd(RCE_OFS_BUSY, 32'h4);
		rd(RCE_OFS_CMPB, 32'h00A5A5A5);
		$display("test reset and compare done");
		wr(RCE_OFS_IEN, 32'h7);
		for (int i = 0; i < 3; i++)
		begin
			wr(RCE_OFS_FSET, 32'h1 << i);
			wr(RCE_OFS_FSET, 32'h0);
			rd(RCE_OFS_FLAGS, 32'h1 << i);
			#1 chk("irq", {31'h0, irq_q}, 32'h1);
			wr(RCE_OFS_FCLR, 32'h1 << i);
			rd(RCE_OFS_FLAGS, 32'h0);
			#1 chk("irq", {31'h0, irq_q}, 32'h0);
		end
		rd(RCE_OFS_FSET, 32'h0);
		rd(RCE_OFS_FCLR, 32'h0);
		rd(8'h30, 32'h0);
		wr(RCE_OFS_IEN, 32'h0);
		wr(RCE_OFS_FSET, 32'h7);
		rd(RCE_OFS_FLAGS, 32'h7);
		#1 chk("irq", {31'h0, irq_q}, 32'h0);
		wr(RCE_OFS_FCLR, 32'h7);
		$display("test flags done");
		wr(RCE_OFS_CMPA, 32'h3);
		wr(RCE_OFS_CMPB, 32'h5);
		// plain count, then overflow, then wrap at compare a so b and overflow never fire
		run(3'h1, 32'h0, 32'h6, 1);
		run(3'h1, 32'h00FFFFF8, 32'h7, 2);
		wr(RCE_OFS_FCLR, 32'h7);
		run(3'h5, 32'h0, 32'h2, 2);
		$display("test counting done");
		give_verdict;
	end
	initial
	begin
		#20000;
		n_fail++;
		give_verdict;
	end
endmodule // tb
bind rce_top rce_chk u_chk (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
	.irq_q(irq_q), .timer_start_q(timer_start_q));
